// file: hw/ctx_exec_consts.svh
`ifndef CTX_EXEC_CONSTS_SVH
`define CTX_EXEC_CONSTS_SVH
// instruction lengths in bytes
`define LEN_BIT_MEM 16'h0004
`define LEN_BIT_REG 16'h0003
`define LEN_DEC_REG 16'h0002
`define LEN_DEC_SADDR 16'h0003
`define LEN_CTX_BREAK 16'h0002
`define LEN_FILL 16'h0002
// status word fields
`define PSW_CY 0
`define PSW_RSS 5
`define PSW_RBS_LSB 12
`define PSW_IE 15
// short area and special register windows
`define SADDR_BASE 16'hfe00
`define SFR_BASE 16'hff00
`define SADDR_WRAP 8'h20
// byte registers inside one bank
`define REG_X 4'h0
`define REG_A 4'h1
`define REG_C 4'h2
`define REG_R4 4'h4
`define REG_R5 4'h5
`define REG_R6 4'h6
`define REG_R7 4'h7
`define REG_E 4'hc
`define REG_D 4'hd
// reset values
`define PC_RESET 16'h0000
`define PSW_RESET 16'h0000
`define IN_SERVICE_PRIORITY_REG_RESET 8'h00
`endif

// file: hw/ctx_exec_pkg.sv
package ctx_exec_pkg;
  typedef enum logic [2:0] {
    OP_BRANCH_TRUE_CLEAR = 3'b000,
    OP_BRANCH_FALSE_SET = 3'b001,
    OP_DECREMENT_BRANCH_NONZERO = 3'b010,
    OP_SOFTWARE_CONTEXT_BREAK = 3'b011,
    OP_HW_CONTEXT_RETURN = 3'b100,
    OP_SW_CONTEXT_RETURN = 3'b101,
    OP_REPEAT_BYTE_FILL = 3'b110
  } op_type;
  typedef enum logic [2:0] {
    OPD_SADDR = 3'b000,
    OPD_SFR = 3'b001,
    OPD_ACC = 3'b010,
    OPD_XREG = 3'b011,
    OPD_STATUS_HIGH = 3'b100,
    OPD_STATUS_LOW = 3'b101,
    OPD_BANK_REG = 3'b110
  } opd_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXEC = 3'b001,
    ST_WAIT = 3'b010,
    ST_MODIFY = 3'b011,
    ST_FILL = 3'b100
  } state_type;
  typedef struct packed {
    op_type op;
    opd_type opd;
    logic [2:0] bitSel;
    logic [7:0] addr8;
    logic [3:0] regIdx;
    logic [2:0] bankNum;
    logic [7:0] disp;
    logic [15:0] imm;
    logic down;
  } instr_type;
endpackage

// file: hw/bit_branch_context_switch_exec.sv
`timescale 1ns/1ps
`include "ctx_exec_consts.svh"
module bit_branch_context_switch_exec
  import ctx_exec_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire instr_type instrIn,
  input wire logic irqPending,
  input wire logic [7:0] memRdData,
  input wire logic regWrEn,
  input wire logic [2:0] regWrBank,
  input wire logic [3:0] regWrIdx,
  input wire logic [7:0] regWrData,
  input wire logic [2:0] regRdBank,
  input wire logic [3:0] regRdIdx,
  input wire logic ctrlLoad,
  input wire logic [15:0] pcIn,
  input wire logic [15:0] pswIn,
  input wire logic [7:0] isprIn,
  output logic [15:0] pc_q,
  output logic [15:0] psw_q,
  output logic [7:0] in_service_priority_reg_q,
  output logic [15:0] memAddr_q,
  output logic [7:0] memWrData_q,
  output logic memRd_q,
  output logic memWr_q,
  output logic memLock_q,
  output logic busy_q,
  output logic done_q,
  output logic suspend_q,
  output logic [7:0] regRdData_q
);
  logic [1:0] rstSync_q;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rstSync_q <= 2'b00;
    else
      rstSync_q <= {rstSync_q[0], 1'b1};
  end
  wire rstn = rstSync_q[1];

  // eight banks of sixteen byte registers
  logic [7:0] bankMem [0:127];
  state_type state_q;
  instr_type cur_q;

  wire [2:0] rbs = psw_q[`PSW_RBS_LSB +: 3];
  wire [7:0] regA = bankMem[{rbs, `REG_A}];
  wire [7:0] regX = bankMem[{rbs, `REG_X}];
  wire [7:0] regC = bankMem[{rbs, `REG_C}];
  wire [15:0] regDE = {bankMem[{rbs, `REG_D}], bankMem[{rbs, `REG_E}]};
  wire [15:0] curR54 = {bankMem[{rbs, `REG_R5}], bankMem[{rbs, `REG_R4}]};
  wire [15:0] curR76 = {bankMem[{rbs, `REG_R7}], bankMem[{rbs, `REG_R6}]};
  wire [15:0] brkR54 = {bankMem[{cur_q.bankNum, `REG_R5}], bankMem[{cur_q.bankNum, `REG_R4}]};
  wire [7:0] regSel = bankMem[{rbs, cur_q.regIdx}];

  wire isBitOp = cur_q.op == OP_BRANCH_TRUE_CLEAR || cur_q.op == OP_BRANCH_FALSE_SET;
  wire isDec = cur_q.op == OP_DECREMENT_BRANCH_NONZERO;
  wire isMemOpd = cur_q.opd == OPD_SADDR || cur_q.opd == OPD_SFR;
  wire [15:0] opdAddr = cur_q.opd == OPD_SFR ? (`SFR_BASE | {8'h00, cur_q.addr8}) :
    cur_q.addr8 < `SADDR_WRAP ? (`SFR_BASE | {8'h00, cur_q.addr8}) :
    (`SADDR_BASE | {8'h00, cur_q.addr8});

  wire [7:0] srcByte = isMemOpd ? memRdData :
    isDec ? regSel :
    cur_q.opd == OPD_ACC ? regA :
    cur_q.opd == OPD_XREG ? regX :
    cur_q.opd == OPD_STATUS_HIGH ? psw_q[15:8] : psw_q[7:0];
  wire [7:0] bitMask = 8'h01 << cur_q.bitSel;
  wire testBit = |(srcByte & bitMask);
  wire [7:0] decByte = srcByte - 8'h01;
  wire taken = cur_q.op == OP_BRANCH_TRUE_CLEAR ? testBit :
    cur_q.op == OP_BRANCH_FALSE_SET ? !testBit : decByte != 8'h00;
  wire [7:0] newByte = cur_q.op == OP_BRANCH_TRUE_CLEAR ? (srcByte & ~bitMask) :
    cur_q.op == OP_BRANCH_FALSE_SET ? (srcByte | bitMask) : decByte;
  wire writeBack = isDec || taken;
  wire [15:0] opLen = isBitOp ? (isMemOpd ? `LEN_BIT_MEM : `LEN_BIT_REG) :
    (isMemOpd ? `LEN_DEC_SADDR : `LEN_DEC_REG);
  wire [15:0] nextPc = pc_q + opLen;
  wire [15:0] target = nextPc + {{8{cur_q.disp[7]}}, cur_q.disp};

  // one point where a bit or decrement op resolves, for both operand kinds
  wire exeNow = (state_q == ST_EXEC && (isBitOp || isDec) && !isMemOpd) ||
    state_q == ST_MODIFY;
  wire regOpdWr = exeNow && writeBack && !isMemOpd &&
    (isDec || cur_q.opd == OPD_ACC || cur_q.opd == OPD_XREG);
  wire [3:0] regOpdIdx = isDec ? cur_q.regIdx : cur_q.opd == OPD_ACC ? `REG_A : `REG_X;
  wire pswOpdWr = exeNow && isBitOp && taken &&
    (cur_q.opd == OPD_STATUS_LOW || cur_q.opd == OPD_STATUS_HIGH);
  wire [7:0] fillC = regC - 8'h01;
  wire [15:0] fillDE = cur_q.down ? regDE - 16'h0001 : regDE + 16'h0001;
  wire fillStep = state_q == ST_FILL && !irqPending;
  wire isCtxRet = cur_q.op == OP_HW_CONTEXT_RETURN || cur_q.op == OP_SW_CONTEXT_RETURN;
  // the break saves its own length, opLen only knows the branch forms
  wire [15:0] brkNext = pc_q + `LEN_CTX_BREAK;
  function automatic logic [7:0] topBit(input logic [7:0] v);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++)
      if (v[i])
        m = 8'h01 << i;
    return m;
  endfunction
  wire [7:0] isprTop = topBit(in_service_priority_reg_q);

  always_ff @(posedge clk)
  begin
    if (regWrEn && state_q == ST_IDLE)
      bankMem[{regWrBank, regWrIdx}] <= regWrData;
    if (regOpdWr)
      bankMem[{rbs, regOpdIdx}] <= newByte;
    if (state_q == ST_EXEC && cur_q.op == OP_SOFTWARE_CONTEXT_BREAK)
    begin
      bankMem[{cur_q.bankNum, `REG_R5}] <= brkNext[15:8];
      bankMem[{cur_q.bankNum, `REG_R4}] <= brkNext[7:0];
      bankMem[{cur_q.bankNum, `REG_R7}] <= psw_q[15:8];
      bankMem[{cur_q.bankNum, `REG_R6}] <= psw_q[7:0];
    end
    if (state_q == ST_EXEC && isCtxRet)
    begin
      bankMem[{rbs, `REG_R5}] <= cur_q.imm[15:8];
      bankMem[{rbs, `REG_R4}] <= cur_q.imm[7:0];
    end
    if (fillStep)
    begin
      bankMem[{rbs, `REG_D}] <= fillDE[15:8];
      bankMem[{rbs, `REG_E}] <= fillDE[7:0];
      bankMem[{rbs, `REG_C}] <= fillC;
    end
    regRdData_q <= bankMem[{regRdBank, regRdIdx}];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_IDLE;
      cur_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      suspend_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      suspend_q <= 1'b0;
      case (state_q)
        ST_IDLE:
          if (start)
          begin
            cur_q <= instrIn;
            state_q <= ST_EXEC;
            busy_q <= 1'b1;
          end
        ST_EXEC:
          if (cur_q.op == OP_REPEAT_BYTE_FILL)
            state_q <= ST_FILL;
          else if ((isBitOp || isDec) && isMemOpd)
            state_q <= ST_WAIT;
          else
          begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        ST_WAIT:
          state_q <= ST_MODIFY;
        ST_MODIFY:
        begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        ST_FILL:
          if (irqPending || fillC == 8'h00)
          begin
            // suspension leaves PC on the fill so the handler returns into it
            suspend_q <= irqPending;
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  wire [15:0] pswBitNew = cur_q.opd == OPD_STATUS_LOW ? {psw_q[15:8], newByte} :
    {newByte, psw_q[7:0]};

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pc_q <= `PC_RESET;
      psw_q <= `PSW_RESET;
      in_service_priority_reg_q <= `IN_SERVICE_PRIORITY_REG_RESET;
    end
    else if (ctrlLoad && state_q == ST_IDLE)
    begin
      pc_q <= pcIn;
      psw_q <= pswIn;
      in_service_priority_reg_q <= isprIn;
    end
    else if (exeNow)
    begin
      pc_q <= taken ? target : nextPc;
      if (pswOpdWr)
        psw_q <= pswBitNew;
    end
    else if (state_q == ST_EXEC && cur_q.op == OP_SOFTWARE_CONTEXT_BREAK)
    begin
      pc_q <= brkR54;
      psw_q[`PSW_RBS_LSB +: 3] <= cur_q.bankNum;
      psw_q[`PSW_RSS] <= 1'b0;
      psw_q[`PSW_IE] <= 1'b0;
    end
    else if (state_q == ST_EXEC && isCtxRet)
    begin
      pc_q <= curR54;
      psw_q <= curR76;
      if (cur_q.op == OP_HW_CONTEXT_RETURN)
        in_service_priority_reg_q <= in_service_priority_reg_q & ~isprTop;
    end
    else if (fillStep && fillC == 8'h00)
      pc_q <= pc_q + `LEN_FILL;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      memAddr_q <= 16'h0000;
      memWrData_q <= 8'h00;
      memRd_q <= 1'b0;
      memWr_q <= 1'b0;
      memLock_q <= 1'b0;
    end
    else
    begin
      memRd_q <= state_q == ST_EXEC && (isBitOp || isDec) && isMemOpd;
      memWr_q <= (state_q == ST_MODIFY && writeBack) || fillStep;
      if (state_q == ST_EXEC && (isBitOp || isDec) && isMemOpd)
      begin
        memAddr_q <= opdAddr;
        memLock_q <= 1'b1;
      end
      else if (state_q == ST_IDLE)
        memLock_q <= 1'b0;
      if (state_q == ST_MODIFY)
        memWrData_q <= newByte;
      if (fillStep)
      begin
        memAddr_q <= regDE;
        memWrData_q <= regA;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence rmwSeq;
    memRd_q && memLock_q ##1 memLock_q ##1 memLock_q;
  endsequence
  clr_branch_a: assert property (
    exeNow && cur_q.op == OP_BRANCH_TRUE_CLEAR && testBit |=> pc_q == $past(target))
    else $error("set bit did not branch");
  clr_flag_a: assert property (
    exeNow && cur_q.op == OP_BRANCH_TRUE_CLEAR && cur_q.opd == OPD_STATUS_LOW && testBit
    |=> (psw_q[7:0] & $past(bitMask)) == 8'h00)
    else $error("status flag not cleared");
  set_branch_a: assert property (
    exeNow && cur_q.op == OP_BRANCH_FALSE_SET
    |=> pc_q == ($past(testBit) ? $past(nextPc) : $past(target)))
    else $error("set-on-false branch wrong");
  set_flag_a: assert property (
    exeNow && cur_q.op == OP_BRANCH_FALSE_SET && cur_q.opd == OPD_STATUS_LOW && !testBit
    |=> (psw_q[7:0] & $past(bitMask)) == $past(bitMask))
    else $error("status flag not set");
  fall_length_a: assert property (
    exeNow && isBitOp && !taken
    |=> pc_q - $past(pc_q) == ($past(isMemOpd) ? `LEN_BIT_MEM : `LEN_BIT_REG))
    else $error("fall-through length wrong");
  dec_write_a: assert property (
    state_q == ST_MODIFY && isDec |=> memWr_q && memWrData_q == $past(memRdData) - 8'h01)
    else $error("decrement not written back");
  dec_branch_a: assert property (
    exeNow && isDec && decByte == 8'h00 |=> pc_q == $past(nextPc))
    else $error("zero result branched");
  dec_flags_a: assert property (
    exeNow && isDec |=> $stable(psw_q))
    else $error("decrement touched flags");
  brk_bank_a: assert property (
    state_q == ST_EXEC && cur_q.op == OP_SOFTWARE_CONTEXT_BREAK
    |=> rbs == $past(cur_q.bankNum) && !psw_q[`PSW_IE] && !psw_q[`PSW_RSS])
    else $error("context break state wrong");
  hw_ret_a: assert property (
    state_q == ST_EXEC && cur_q.op == OP_HW_CONTEXT_RETURN
    |=> in_service_priority_reg_q == ($past(in_service_priority_reg_q) & ~$past(isprTop)))
    else $error("in-service bit not cleared");
  sw_ret_a: assert property (
    state_q == ST_EXEC && cur_q.op == OP_SW_CONTEXT_RETURN |=> $stable(in_service_priority_reg_q))
    else $error("software return touched in-service");
  rmw_lock_a: assert property (
    memRd_q |-> rmwSeq)
    else $error("lock dropped in read-modify-write");
  fill_store_a: assert property (
    fillStep |=> memWr_q && memAddr_q == $past(regDE) && memWrData_q == $past(regA))
    else $error("fill store wrong");
  fill_suspend_a: assert property (
    state_q == ST_FILL && irqPending |=> suspend_q && !memWr_q && $stable(pc_q))
    else $error("fill not suspended");
endmodule // bit_branch_context_switch_exec

// file: tb/tb_top.sv
`timescale 1ns/1ps
`include "ctx_exec_consts.svh"
module tb_top
  import ctx_exec_pkg::*;
;
  logic clk = 0, resetn = 0, start = 0, irqPending = 0, regWrEn = 0, ctrlLoad = 0;
  instr_type instrIn = '0;
  logic [7:0] memRdData = 8'h00, regWrData = 8'h00, isprIn = 8'h00, memByte = 8'h00;
  logic [2:0] regWrBank = 3'h0, regRdBank = 3'h0;
  logic [3:0] regWrIdx = 4'h0, regRdIdx = 4'h0;
  logic [15:0] pcIn = 16'h0000, pswIn = 16'h0000;
  logic [15:0] pc_q, psw_q, memAddr_q;
  logic [7:0] in_service_priority_reg_q, memWrData_q, regRdData_q;
  logic memRd_q, memWr_q, memLock_q, busy_q, done_q, suspend_q;
  logic rdHold = 0, sawSusp = 0;
  logic [15:0] wrAddr[$];
  logic [7:0] wrData[$];
  logic wrLock[$];
  int miscompares = 0, nChecks = 0;

  always #4 clk = ~clk;

  bit_branch_context_switch_exec dut_u (
    .clk(clk), .resetn(resetn), .start(start), .instrIn(instrIn), .irqPending(irqPending),
    .memRdData(memRdData), .regWrEn(regWrEn), .regWrBank(regWrBank), .regWrIdx(regWrIdx),
    .regWrData(regWrData), .regRdBank(regRdBank), .regRdIdx(regRdIdx), .ctrlLoad(ctrlLoad),
    .pcIn(pcIn), .pswIn(pswIn), .isprIn(isprIn), .pc_q(pc_q), .psw_q(psw_q), .in_service_priority_reg_q(in_service_priority_reg_q),
    .memAddr_q(memAddr_q), .memWrData_q(memWrData_q), .memRd_q(memRd_q), .memWr_q(memWr_q),
    .memLock_q(memLock_q), .busy_q(busy_q), .done_q(done_q), .suspend_q(suspend_q),
    .regRdData_q(regRdData_q)
  );

  // read data valid in the request cycle and the cycle after it; otherwise show garbage
  always @(posedge clk) rdHold <= memRd_q;
  always @(negedge clk) memRdData <= (memRd_q || rdHold) ? memByte : ~memByte;
  always @(negedge clk)
  begin
    if (memWr_q === 1'b1)
    begin
      wrAddr.push_back(memAddr_q);
      wrData.push_back(memWrData_q);
      wrLock.push_back(memLock_q);
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    nChecks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  task automatic setReg(logic [2:0] b, logic [3:0] i, logic [7:0] d);
    @(negedge clk);
    regWrEn = 1;
    regWrBank = b;
    regWrIdx = i;
    regWrData = d;
    @(negedge clk);
    regWrEn = 0;
  endtask

  task automatic setCtrl(logic [15:0] pc, logic [15:0] psw, logic [7:0] is);
    @(negedge clk);
    ctrlLoad = 1;
    pcIn = pc;
    pswIn = psw;
    isprIn = is;
    @(negedge clk);
    ctrlLoad = 0;
  endtask

  task automatic chkReg(string nm, logic [2:0] b, logic [3:0] i, logic [7:0] e);
    @(negedge clk);
    regRdBank = b;
    regRdIdx = i;
    @(negedge clk);
    chk(nm, {8'h00, e}, {8'h00, regRdData_q});
  endtask

  function automatic instr_type mk(op_type o, opd_type d, logic [2:0] b, logic [7:0] a,
                                   logic [7:0] ds, logic [3:0] ri);
    mk = '0;
    mk.op = o;
    mk.opd = d;
    mk.bitSel = b;
    mk.addr8 = a;
    mk.disp = ds;
    mk.regIdx = ri;
  endfunction

  task automatic run(instr_type ins);
    int n;
    @(negedge clk);
    wrAddr.delete();
    wrData.delete();
    wrLock.delete();
    instrIn = ins;
    start = 1;
    @(negedge clk);
    start = 0;
    chk("busy", 16'h0001, {15'h0000, busy_q});
    n = 0;
    while (done_q !== 1'b1 && n < 600)
    begin
      @(negedge clk);
      n++;
    end
    if (done_q !== 1'b1)
    begin
      $display("wrong value done_q expected 1 seen %b", done_q);
      miscompares++;
      finish_test();
    end
    else
    begin
      sawSusp = suspend_q;
      chk("busy", 16'h0000, {15'h0000, busy_q});
      // let the store of the done cycle reach the write log first
      @(negedge clk);
    end
  endtask

  task automatic tBitReg();
    instr_type c = mk(OP_BRANCH_TRUE_CLEAR, OPD_ACC, 3'h2, 8'h00, 8'hf0, 4'h0);
    instr_type s = mk(OP_BRANCH_FALSE_SET, OPD_XREG, 3'h7, 8'h00, 8'h10, 4'h0);
    setCtrl(16'h1000, 16'h0000, 8'h00);
    setReg(3'h0, `REG_A, 8'h04);
    setReg(3'h0, `REG_X, 8'h00);
    run(c);
    chk("pc", 16'h0ff3, pc_q);
    chkReg("acc", 3'h0, `REG_A, 8'h00);
    run(c);
    chk("pc", 16'h0ff6, pc_q);
    run(s);
    chk("pc", 16'h1009, pc_q);
    chkReg("xreg", 3'h0, `REG_X, 8'h80);
    run(s);
    chk("pc", 16'h100c, pc_q);
    $display("test bit_reg done");
  endtask

  task automatic tBitPsw();
    setCtrl(16'h2000, 16'h0001, 8'h00);
    run(mk(OP_BRANCH_TRUE_CLEAR, OPD_STATUS_LOW, 3'h0, 8'h00, 8'h80, 4'h0));
    chk("pc", 16'h1f83, pc_q);
    chk("psw", 16'h0000, psw_q);
    run(mk(OP_BRANCH_FALSE_SET, OPD_STATUS_LOW, 3'h0, 8'h00, 8'h7f, 4'h0));
    chk("pc", 16'h2005, pc_q);
    chk("psw", 16'h0001, psw_q);
    run(mk(OP_BRANCH_FALSE_SET, OPD_STATUS_HIGH, 3'h0, 8'h00, 8'h10, 4'h0));
    chk("pc", 16'h2018, pc_q);
    chk("psw", 16'h0101, psw_q);
    $display("test bit_psw done");
  endtask

  task automatic tBitMem();
    setCtrl(16'h0400, 16'h0000, 8'h00);
    memByte = 8'h08;
    run(mk(OP_BRANCH_TRUE_CLEAR, OPD_SADDR, 3'h3, 8'h40, 8'h04, 4'h0));
    chk("pc", 16'h0408, pc_q);
    chk("writes", 16'h0001, 16'(wrAddr.size()));
    chk("wraddr", 16'hfe40, wrAddr[0]);
    chk("wrdata", 16'h0000, {8'h00, wrData[0]});
    chk("lock", 16'h0001, {15'h0000, wrLock[0]});
    memByte = 8'h00;
    run(mk(OP_BRANCH_FALSE_SET, OPD_SFR, 3'h0, 8'h10, 8'hf8, 4'h0));
    chk("pc", 16'h0404, pc_q);
    chk("wraddr", 16'hff10, wrAddr[0]);
    chk("wrdata", 16'h0001, {8'h00, wrData[0]});
    memByte = 8'h01;
    run(mk(OP_BRANCH_FALSE_SET, OPD_SFR, 3'h0, 8'h10, 8'hf8, 4'h0));
    chk("pc", 16'h0408, pc_q);
    chk("writes", 16'h0000, 16'(wrAddr.size()));
    $display("test bit_mem done");
  endtask

  task automatic tDec();
    instr_type r = mk(OP_DECREMENT_BRANCH_NONZERO, OPD_BANK_REG, 3'h0, 8'h00, 8'h20, `REG_C);
    setCtrl(16'h0500, 16'h00c5, 8'h00);
    setReg(3'h0, `REG_C, 8'h02);
    run(r);
    chk("pc", 16'h0522, pc_q);
    chkReg("creg", 3'h0, `REG_C, 8'h01);
    run(r);
    chk("pc", 16'h0524, pc_q);
    chkReg("creg", 3'h0, `REG_C, 8'h00);
    chk("psw", 16'h00c5, psw_q);
    memByte = 8'h01;
    run(mk(OP_DECREMENT_BRANCH_NONZERO, OPD_SADDR, 3'h0, 8'h30, 8'h10, 4'h0));
    chk("pc", 16'h0527, pc_q);
    chk("wraddr", 16'hfe30, wrAddr[0]);
    chk("wrdata", 16'h0000, {8'h00, wrData[0]});
    chk("psw", 16'h00c5, psw_q);
    $display("test dec done");
  endtask

  task automatic tCtx();
    instr_type ins = mk(OP_SOFTWARE_CONTEXT_BREAK, OPD_BANK_REG, 3'h0, 8'h00, 8'h00, 4'h0);
    setCtrl(16'h2000, 16'h80a1, 8'h26);
    setReg(3'h3, `REG_R4, 8'h34);
    setReg(3'h3, `REG_R5, 8'h12);
    ins.bankNum = 3'h3;
    run(ins);
    chk("pc", 16'h1234, pc_q);
    chk("psw", 16'h3081, psw_q);
    chkReg("r7", 3'h3, `REG_R7, 8'h80);
    chkReg("r6", 3'h3, `REG_R6, 8'ha1);
    chkReg("r5", 3'h3, `REG_R5, 8'h20);
    chkReg("r4", 3'h3, `REG_R4, 8'h02);
    ins.op = OP_SW_CONTEXT_RETURN;
    ins.imm = 16'h0abc;
    run(ins);
    chk("pc", 16'h2002, pc_q);
    chk("psw", 16'h80a1, psw_q);
    chk("in_service_priority_reg", 16'h0026, {8'h00, in_service_priority_reg_q});
    chkReg("r5", 3'h3, `REG_R5, 8'h0a);
    chkReg("r4", 3'h3, `REG_R4, 8'hbc);
    // a fresh hardware-switch frame in bank 5, never the break frame
    setCtrl(16'h6000, 16'h5000, 8'h26);
    setReg(3'h5, `REG_R4, 8'h00);
    setReg(3'h5, `REG_R5, 8'h70);
    setReg(3'h5, `REG_R6, 8'h34);
    setReg(3'h5, `REG_R7, 8'h12);
    ins.op = OP_HW_CONTEXT_RETURN;
    ins.imm = 16'h4567;
    run(ins);
    chk("pc", 16'h7000, pc_q);
    chk("psw", 16'h1234, psw_q);
    chk("in_service_priority_reg", 16'h0006, {8'h00, in_service_priority_reg_q});
    chkReg("r5", 3'h5, `REG_R5, 8'h45);
    chkReg("r4", 3'h5, `REG_R4, 8'h67);
    $display("test ctx done");
  endtask

  task automatic tFill();
    instr_type ins = mk(OP_REPEAT_BYTE_FILL, OPD_BANK_REG, 3'h0, 8'h00, 8'h00, 4'h0);
    int n1;
    setCtrl(16'h3000, 16'h0000, 8'h00);
    setReg(3'h0, `REG_A, 8'h5a);
    setReg(3'h0, `REG_C, 8'h03);
    setReg(3'h0, `REG_D, 8'hfe);
    setReg(3'h0, `REG_E, 8'h80);
    run(ins);
    chk("writes", 16'h0003, 16'(wrAddr.size()));
    chk("suspend", 16'h0000, {15'h0000, sawSusp});
    for (int i = 0; i < 3; i++)
    begin
      chk("wraddr", 16'hfe80 + 16'(i), wrAddr[i]);
      chk("wrdata", 16'h005a, {8'h00, wrData[i]});
    end
    chk("pc", 16'h3002, pc_q);
    chkReg("creg", 3'h0, `REG_C, 8'h00);
    chkReg("ereg", 3'h0, `REG_E, 8'h83);
    setReg(3'h0, `REG_C, 8'h02);
    irqPending = 1;
    ins.down = 1'b1;
    run(ins);
    n1 = wrAddr.size();
    chk("suspend", 16'h0001, {15'h0000, sawSusp});
    chk("pc", 16'h3002, pc_q);
    chkReg("creg", 3'h0, `REG_C, 8'(2 - n1));
    irqPending = 0;
    run(ins);
    chk("writes", 16'h0002, 16'(n1 + wrAddr.size()));
    chk("wraddr", 16'hfe82, wrAddr[$]);
    chk("pc", 16'h3004, pc_q);
    chkReg("ereg", 3'h0, `REG_E, 8'h81);
    $display("test fill done");
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    resetn = 1;
    repeat (4) @(negedge clk);
    tBitReg();
    tBitPsw();
    tBitMem();
    tDec();
    tCtx();
    tFill();
    finish_test();
  end
endmodule // tb_top
